// ### level_sync.sv
// Two-stage synchroniser for slow levels and toggles.
// Assumes inputs are quasi-static relative to the receiving clock.
module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : level_sync

// ### spi_byte_link.sv
// Serial-port byte engine on the link clock.
// Assumes mosi is sampled and miso updated on rising sclk; cs_b ends a frame.
module spi_byte_link
   import temp_ram_pkg::*;
(
   input  wire logic        sclk,
   input  wire logic        rst_n,
   input  wire logic        cs_b,
   input  wire logic        mosi,
   input  wire logic [7:0]  tx_byte,
   output logic             miso,
   output logic             miso_oe,
   output logic [7:0]       rx_byte,
   output link_phase_t      rx_phase,
   output logic             rx_toggle
);
   logic [2:0]  bit_cnt;
   logic [6:0]  shift_in;
   logic [6:0]  shift_out;
   link_phase_t phase;
   wire         byte_end = (bit_cnt == 3'h7);

   // Frame state is cleared by cs_b itself, since sclk may stop between frames
   always_ff @(posedge sclk or posedge cs_b)
   begin
      if (cs_b)
      begin
         bit_cnt   <= 3'h0;
         shift_in  <= 7'h00;
         shift_out <= 7'h00;
         phase     <= PH_INSTR;
         miso      <= 1'b0;
         miso_oe   <= 1'b0;
      end
      else
      begin
         bit_cnt  <= bit_cnt + 3'h1;
         shift_in <= {shift_in[5:0], mosi};
         miso_oe  <= 1'b1;
         if (bit_cnt == 3'h0)
         begin
            // tx_byte is held by the system side during the byte gap
            miso      <= tx_byte[7];
            shift_out <= tx_byte[6:0];
         end
         else
         begin
            miso      <= shift_out[6];
            shift_out <= {shift_out[5:0], 1'b0};
         end
         if (byte_end && phase != PH_DATA)
            phase <= link_phase_t'(phase + 2'h1);
      end
   end

   // Outside the frame reset so a completed byte survives cs_b rising
   always_ff @(posedge sclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_byte   <= 8'h00;
         rx_phase  <= PH_INSTR;
         rx_toggle <= 1'b0;
      end
      else if (!cs_b && byte_end)
      begin
         rx_byte   <= {shift_in, mosi};
         rx_phase  <= phase;
         rx_toggle <= ~rx_toggle;
      end
   end
endmodule : spi_byte_link

// ### spi_host_model.sv
// Serial host model: instruction, 16-bit address, then four data bytes per frame.
// Assumes the device samples mosi and shifts miso on rising sclk.
module spi_host_model
(
   output logic      sclk,
   output logic      cs_b,
   output logic      mosi,
   input  wire logic miso
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      sclk = 1'b0;
      cs_b = 1'b1;
      mosi = 1'b0;
   end

   // Clock stands low between bytes; the device needs this gap to move each byte
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         mosi = tx[i];
         #24 sclk = 1'b1;
         #24 sclk = 1'b0;
         rx[i] = miso;
      end
      #600 mosi = ~mosi;
   endtask : xfer

   task automatic frame(input logic [7:0] op, input logic [9:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
      logic [7:0] b;
      cs_b = 1'b0;
      #100;
      xfer(op, b);
      xfer({6'h00, a[9:8]}, b);
      xfer(a[7:0], b);
      for (int k = 3; k >= 0; k--)
      begin
         xfer(wd[8*k +: 8], b);
         rd[8*k +: 8] = b;
      end
      cs_b = 1'b1;
      #500;
   endtask : frame
endmodule : spi_host_model

// ### temp_ram_control.sv
// Byte RAM map, serial-port access and operating sequence of the sensor front end.
// Assumes the measurement engine answers meas_start with meas_done on clock.
// Overview of operation
// - Results at 0x010-0x037 readable over serial
// - Instruction 0x03, address, then read data
// - Instruction 0x02, address, then written data
// - Instruction with bit 1 clear does nothing
// - Assignment data 0x200-0x227 host writable
// - Writing address 0x000 with bit 7 set starts a conversion
// - Channel mask bytes at 0x0F4-0x0F7
// - Global config 0x0F0, mux delay 0x0FF
// - Custom table 0x250-0x3CF; reserved undefined
// - Wake-up takes 200 ms after power
// - Status hidden during first 100 ms
// - Status reads 0x80 while initialising
// - Start-up end: interrupt high, status 0x40
// - Assignment state entered after start-up
// - Command byte selects the converted channel
// - Conversion starts at once with paired channel
// - RAM locked during conversion except status read
// - Conversion end: interrupt high, start clear, done set
// - Full RAM access restored after conversion
// - Sleep exit or reset restarts start-up
// - Ten four-byte assignment words, channel one first
// - Assignment words reset to zero, zero disables
// - Top five assignment bits give sensor type
module temp_ram_control
   import temp_ram_pkg::*;
#(
   parameter int POWER_CYCLES = POWER_PHASE_CYCLES,
   parameter int INIT_CYCLES  = INIT_PHASE_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        sleep_exit,
   input  wire logic        sclk,
   input  wire logic        cs_b,
   input  wire logic        mosi,
   output logic             miso,
   output logic             miso_oe,
   output logic             interrupt_out,
   output logic             meas_start,
   output logic [4:0]       meas_channel,
   output logic [4:0]       meas_pair_channel,
   output logic [4:0]       meas_sensor_type,
   input  wire logic        meas_done,
   input  wire logic [31:0] meas_result,
   output logic [7:0]       global_config,
   output logic [7:0]       mux_delay
);
   logic        rst_meta;
   logic        rst_n;
   logic [7:0]  ram [RAM_BYTES];
   logic [7:0]  cmd_status;
   logic [7:0]  tx_byte;
   logic [15:0] addr;
   logic        op_read;
   logic        op_write;
   logic        tgl_prev;
   logic        skip_pending;
   logic [31:0] phase_cnt;
   dev_state_t  state;
   dev_state_t  next_state;
   logic [7:0]  rx_byte;
   link_phase_t rx_phase;
   logic        rx_toggle;
   logic        cs_sync;
   logic        tgl_sync;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   spi_byte_link u_link (
      .sclk      (sclk),
      .rst_n     (rst_n),
      .cs_b      (cs_b),
      .mosi      (mosi),
      .tx_byte   (tx_byte),
      .miso      (miso),
      .miso_oe   (miso_oe),
      .rx_byte   (rx_byte),
      .rx_phase  (rx_phase),
      .rx_toggle (rx_toggle)
   );

   // Byte and phase are held in the link domain until the next byte ends
   level_sync #(.WIDTH(2)) u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     ({cs_b, rx_toggle}),
      .q     ({cs_sync, tgl_sync})
   );

   wire        byte_event  = tgl_sync ^ tgl_prev;
   wire        ev_instr    = byte_event && rx_phase == PH_INSTR;
   wire        ev_addr_lo  = byte_event && rx_phase == PH_ADDR_LO;
   wire        ev_data     = byte_event && rx_phase == PH_DATA;
   wire [15:0] look_addr   = ev_addr_lo ? {addr[15:8], rx_byte} : addr;
   wire [9:0]  look_idx    = look_addr[9:0];
   wire        look_mapped = look_addr[15:10] == 6'h00;
   wire [9:0]  wr_idx      = addr[9:0];
   wire        wr_mapped   = addr[15:10] == 6'h00;

   wire in_key    = wr_idx >= ADDR_KEY_FIRST && wr_idx <= ADDR_KEY_LAST;
   wire in_mask   = wr_idx >= ADDR_MASK_FIRST && wr_idx <= ADDR_MASK_LAST;
   wire in_single = wr_idx == ADDR_GLOBAL_CONFIG || wr_idx == ADDR_MUX_DELAY;
   wire in_assign = wr_idx >= ADDR_ASSIGN_FIRST && wr_idx <= ADDR_ASSIGN_LAST;
   wire in_custom = wr_idx >= ADDR_CUSTOM_FIRST && wr_idx <= ADDR_CUSTOM_LAST;
   // Results and reserved bytes are never host-written, so reserved reads as zero
   wire writable  = in_key || in_mask || in_single || in_assign || in_custom;

   wire host_wr    = ev_data && op_write && wr_mapped && state == ST_READY;
   wire host_store = host_wr && writable && wr_idx != ADDR_COMMAND_STATUS;
   wire cmd_write  = host_wr && wr_idx == ADDR_COMMAND_STATUS;
   wire start_cmd  = cmd_write && rx_byte[STATUS_START_BIT];

   wire [7:0] status_view = (state == ST_POWER) ? STATUS_HIDDEN :
                            (state == ST_INIT)  ? STATUS_INIT :
                            cmd_status;
   wire [7:0] read_value  = !look_mapped ? 8'h00 :
                            (look_idx == ADDR_COMMAND_STATUS) ? status_view :
                            (state != ST_READY) ? 8'h00 :
                            ram[look_idx];

   // Channel n owns four bytes from the assignment base, most significant first
   wire [4:0] start_ch   = rx_byte[4:0];
   wire       ch_ok      = start_ch != 5'h00 && start_ch <= CHANNEL_COUNT;
   wire [4:0] start_m1   = start_ch - 5'h01;
   wire [9:0] assign_idx = ADDR_ASSIGN_FIRST + {3'b000, start_m1, 2'b00};
   wire [31:0] assign_word = {ram[assign_idx], ram[assign_idx + 10'h001],
                              ram[assign_idx + 10'h002], ram[assign_idx + 10'h003]};
   wire [4:0] start_type = assign_word[TYPE_MSB:TYPE_LSB];
   wire       measure_ok = ch_ok && start_type != 5'h00;
   wire [4:0] conv_m1    = meas_channel - 5'h01;
   wire [9:0] result_idx = ADDR_RESULT_FIRST + {3'b000, conv_m1, 2'b00};
   wire       conv_finish  = state == ST_CONVERT && (meas_done || skip_pending);
   wire       store_result = state == ST_CONVERT && meas_done && !skip_pending;
   wire       power_end  = phase_cnt == 32'(POWER_CYCLES - 1);
   wire       init_end   = phase_cnt == 32'(INIT_CYCLES - 1);

   always_comb
   begin
      next_state = state;
      case (state)
         ST_POWER:   if (power_end) next_state = ST_INIT;
         ST_INIT:    if (init_end) next_state = ST_READY;
         ST_READY:   if (start_cmd) next_state = ST_CONVERT;
         ST_CONVERT: if (conv_finish) next_state = ST_READY;
         default:    next_state = ST_POWER;
      endcase
      if (sleep_exit)
         next_state = ST_POWER;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state         <= ST_POWER;
         phase_cnt     <= 32'h0000_0000;
         interrupt_out <= 1'b0;
      end
      else
      begin
         state         <= next_state;
         phase_cnt     <= (next_state != state) ? 32'h0000_0000 : phase_cnt + 32'h0000_0001;
         interrupt_out <= next_state == ST_READY;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         cmd_status <= STATUS_HIDDEN;
      else if (next_state == ST_POWER)
         cmd_status <= STATUS_HIDDEN;
      else if (state == ST_INIT && init_end)
         cmd_status <= STATUS_READY;
      else if (conv_finish)
         cmd_status <= {1'b0, 1'b1, cmd_status[5:0]};
      else if (cmd_write)
         cmd_status <= rx_byte;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meas_start        <= 1'b0;
         meas_channel      <= 5'h00;
         meas_pair_channel <= 5'h00;
         meas_sensor_type  <= 5'h00;
         skip_pending      <= 1'b0;
      end
      else
      begin
         meas_start <= start_cmd && measure_ok;
         if (start_cmd)
         begin
            meas_channel      <= start_ch;
            meas_pair_channel <= assign_word[PAIR_MSB:PAIR_LSB];
            meas_sensor_type  <= start_type;
            // A disabled or out-of-range channel completes without measuring
            skip_pending      <= !measure_ok;
         end
         else if (conv_finish)
            skip_pending <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         for (int i = 0; i < RAM_BYTES; i++)
            ram[i] <= 8'h00;
      else if (state == ST_POWER)
         for (int i = 0; i < RAM_BYTES; i++)
            ram[i] <= 8'h00;
      else if (store_result)
      begin
         ram[result_idx]           <= meas_result[31:24];
         ram[result_idx + 10'h001] <= meas_result[23:16];
         ram[result_idx + 10'h002] <= meas_result[15:8];
         ram[result_idx + 10'h003] <= meas_result[7:0];
      end
      else if (host_store)
         ram[wr_idx] <= rx_byte;
   end

   // Global configuration and mux delay steer the measurement engine
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         global_config <= 8'h00;
         mux_delay     <= 8'h00;
      end
      else
      begin
         global_config <= ram[ADDR_GLOBAL_CONFIG];
         mux_delay     <= ram[ADDR_MUX_DELAY];
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tgl_prev <= 1'b0;
         op_read  <= 1'b0;
         op_write <= 1'b0;
         addr     <= 16'h0000;
         tx_byte  <= 8'h00;
      end
      else
      begin
         tgl_prev <= tgl_sync;
         if (cs_sync && !byte_event)
         begin
            op_read  <= 1'b0;
            op_write <= 1'b0;
            // A new frame must not shift out the last byte of an earlier read
            tx_byte  <= 8'h00;
         end
         else if (ev_instr)
         begin
            // Bit 1 clear never matches either code
            op_read  <= rx_byte == INSTR_READ;
            op_write <= rx_byte == INSTR_WRITE;
            tx_byte  <= 8'h00;
         end
         else if (byte_event && rx_phase == PH_ADDR_HI)
            addr[15:8] <= rx_byte;
         else if (ev_addr_lo)
         begin
            addr <= op_read ? look_addr + 16'h0001 : look_addr;
            if (op_read)
               tx_byte <= read_value;
         end
         else if (ev_data && op_read)
         begin
            tx_byte <= read_value;
            addr    <= addr + 16'h0001;
         end
         else if (ev_data && op_write)
            addr <= addr + 16'h0001;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_RESULT_STORED: assert property (
      store_result |=> ram[$past(result_idx)] == $past(meas_result[31:24]))
      else $error("result byte not stored");
   AST_READ_FETCH: assert property (
      ev_addr_lo && op_read |=> tx_byte == $past(read_value) && addr == $past(look_addr) + 16'h0001)
      else $error("read data not fetched");
   AST_WRITE_STORE: assert property (
      host_store |=> ram[$past(wr_idx)] == $past(rx_byte))
      else $error("write data not stored");
   AST_INVALID_INSTR: assert property (
      ev_instr && !rx_byte[INSTR_VALID_BIT] |=> !op_read && !op_write)
      else $error("invalid instruction accepted");
   AST_HIDDEN_STATUS: assert property (
      state == ST_POWER && ev_addr_lo && look_mapped && look_idx == 10'h000 |-> read_value == 8'h00)
      else $error("status visible in power phase");
   AST_INIT_STATUS: assert property (
      state == ST_INIT ##1 state == ST_INIT |-> status_view == 8'h80 && !interrupt_out)
      else $error("status not 0x80 during init");
   AST_READY_REACHED: assert property (
      state == ST_INIT && init_end && !sleep_exit |=> state == ST_READY && interrupt_out
                                                    && cmd_status == 8'h40)
      else $error("start-up end not signalled");
   AST_CONV_START: assert property (
      start_cmd && measure_ok && !sleep_exit |=> state == ST_CONVERT && meas_start && !interrupt_out
                                               ##1 !meas_start)
      else $error("conversion did not start");
   AST_LOCKOUT: assert property (
      state == ST_CONVERT && look_idx != 10'h000 |-> read_value == 8'h00 && !host_wr)
      else $error("ram reachable while converting");
   AST_CONV_DONE: assert property (
      conv_finish && !sleep_exit |=> interrupt_out && !cmd_status[7] && cmd_status[6] && state == ST_READY)
      else $error("conversion end not signalled");
   AST_SKIP_DONE: assert property (
      state == ST_CONVERT && skip_pending && !sleep_exit |-> !meas_start ##1 state == ST_READY && interrupt_out)
      else $error("disabled channel did not complete");
   AST_RESTART: assert property (
      sleep_exit |=> state == ST_POWER && !interrupt_out ##1 cmd_status == 8'h00)
      else $error("sleep exit did not restart");

   COV_STARTUP:    cover property (state == ST_INIT ##1 state == ST_READY);
   COV_CONVERSION: cover property (meas_start ##[1:1000] store_result);
   COV_READ:       cover property (ev_addr_lo && op_read ##[1:100] ev_data && op_read);
   COV_WRITE:      cover property (host_store && in_assign);
endmodule : temp_ram_control

// ### temp_ram_pkg.sv
// Shared constants for the temperature front end RAM and sequencer.
// Assumes a 10 MHz system clock; the serial link runs on its own clock.
package temp_ram_pkg;

   localparam int CLOCK_HZ           = 10_000_000;
   localparam int POWER_PHASE_MS     = 100;
   localparam int WAKE_TOTAL_MS      = 200;
   localparam int INIT_PHASE_MS      = WAKE_TOTAL_MS - POWER_PHASE_MS;
   // Longest times, so the cycle counts round down
   localparam int POWER_PHASE_CYCLES = (CLOCK_HZ / 1000) * POWER_PHASE_MS;
   localparam int INIT_PHASE_CYCLES  = (CLOCK_HZ / 1000) * INIT_PHASE_MS;

   localparam int RAM_BYTES = 1024;

   localparam logic [9:0] ADDR_COMMAND_STATUS = 10'h000;
   localparam logic [9:0] ADDR_RESULT_FIRST   = 10'h010;
   localparam logic [9:0] ADDR_RESULT_LAST    = 10'h037;
   localparam logic [9:0] ADDR_KEY_FIRST      = 10'h0b0;
   localparam logic [9:0] ADDR_KEY_LAST       = 10'h0b3;
   localparam logic [9:0] ADDR_EEPROM_RESULT  = 10'h0d0;
   localparam logic [9:0] ADDR_GLOBAL_CONFIG  = 10'h0f0;
   localparam logic [9:0] ADDR_MASK_FIRST     = 10'h0f4;
   localparam logic [9:0] ADDR_MASK_LAST      = 10'h0f7;
   localparam logic [9:0] ADDR_EEPROM_STATUS  = 10'h0f9;
   localparam logic [9:0] ADDR_MUX_DELAY      = 10'h0ff;
   localparam logic [9:0] ADDR_ASSIGN_FIRST   = 10'h200;
   localparam logic [9:0] ADDR_ASSIGN_LAST    = 10'h227;
   localparam logic [9:0] ADDR_CUSTOM_FIRST   = 10'h250;
   localparam logic [9:0] ADDR_CUSTOM_LAST    = 10'h3cf;

   localparam logic [7:0] INSTR_READ      = 8'h03;
   localparam logic [7:0] INSTR_WRITE     = 8'h02;
   localparam int         INSTR_VALID_BIT = 1;

   localparam int         STATUS_START_BIT = 7;
   localparam int         STATUS_DONE_BIT  = 6;
   localparam logic [7:0] STATUS_HIDDEN    = 8'h00;
   localparam logic [7:0] STATUS_INIT      = 8'h80;
   localparam logic [7:0] STATUS_READY     = 8'h40;

   localparam logic [4:0] CHANNEL_COUNT = 5'h0a;
   localparam int         TYPE_MSB      = 31;
   localparam int         TYPE_LSB      = 27;
   localparam int         PAIR_MSB      = 26;
   localparam int         PAIR_LSB      = 22;

   typedef enum logic [1:0] {
      PH_INSTR   = 2'b00,
      PH_ADDR_HI = 2'b01,
      PH_ADDR_LO = 2'b10,
      PH_DATA    = 2'b11
   } link_phase_t;

   typedef enum logic [1:0] {
      ST_POWER   = 2'b00,
      ST_INIT    = 2'b01,
      ST_READY   = 2'b10,
      ST_CONVERT = 2'b11
   } dev_state_t;

endpackage : temp_ram_pkg

// ### testbench.sv
// Self-checking bench for the sensor front end RAM map and sequencer.
// Assumes the host model drives the link; the bench plays the measurement engine.
module testbench
   import temp_ram_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        sleep_exit = 1'b0;
   logic        meas_done = 1'b0;
   logic [31:0] meas_result = 32'h0;
   logic        sclk;
   logic        cs_b;
   logic        mosi;
   logic        miso;
   logic        miso_oe;
   logic        interrupt_out;
   logic        meas_start;
   logic [4:0]  meas_channel;
   logic [4:0]  meas_pair_channel;
   logic [4:0]  meas_sensor_type;
   logic [7:0]  global_config;
   logic [7:0]  mux_delay;
   logic [31:0] rd;
   int          error_cnt = 0;
   int          compares = 0;
   int          starts = 0;
   logic [9:0]  reg_addr [6] = '{ADDR_MASK_FIRST, ADDR_CUSTOM_FIRST, 10'h3cc, ADDR_KEY_FIRST, 10'h224,
                                 ADDR_RESULT_FIRST};
   logic [31:0] reg_data [6] = '{32'h12345678, 32'hdeadbeef, 32'h0badf00d, 32'h55aa55aa, 32'h01020304,
                                 32'h77777777};
   logic [31:0] reg_exp  [6] = '{32'h12345678, 32'hdeadbeef, 32'h0badf00d, 32'h55aa55aa, 32'h01020304, 32'h0};
   logic [7:0]  bad_op   [3] = '{8'h00, 8'h01, 8'hfd};

   always #50 clock = ~clock;

   always @(posedge clock)
      if (meas_start === 1'b1)
         starts <= starts + 1;

   temp_ram_control #(.POWER_CYCLES(100), .INIT_CYCLES(300)) temp_ram_control_inst (
      .clock(clock), .rst_b(rst_b), .sleep_exit(sleep_exit), .sclk(sclk), .cs_b(cs_b), .mosi(mosi),
      .miso(miso), .miso_oe(miso_oe), .interrupt_out(interrupt_out), .meas_start(meas_start),
      .meas_channel(meas_channel), .meas_pair_channel(meas_pair_channel),
      .meas_sensor_type(meas_sensor_type), .meas_done(meas_done), .meas_result(meas_result),
      .global_config(global_config), .mux_delay(mux_delay));

   // An undriven line shows the opposite of the cleared miso, so it always reads 1, never a stale copy
   spi_host_model spi_host_model_inst (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso_oe ? miso : ~miso));

   task automatic finish_test();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      chk({24'h0, got}, {24'h0, exp});
   endtask : chk8

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      spi_host_model_inst.frame(INSTR_WRITE, a, d, rd);
   endtask : wr

   task automatic rdw(input logic [9:0] a);
      spi_host_model_inst.frame(INSTR_READ, a, 32'h0, rd);
   endtask : rdw

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc

   task automatic wait_ready();
      int n;
      n = 0;
      while (interrupt_out !== 1'b1 && n < 2000)
      begin
         @(posedge clock);
         n++;
      end
      if (n >= 2000)
      begin
         error_cnt++;
         $display("ready wait timed out at t=%0t", $time);
         finish_test();
      end
      #1;
   endtask : wait_ready

   initial
   begin
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      cyc(3);
      rdw(ADDR_COMMAND_STATUS);
      chk8(rd[31:24], STATUS_HIDDEN);
      cyc(40);
      rdw(ADDR_COMMAND_STATUS);
      chk8(rd[31:24], STATUS_INIT);
      chk8({7'h0, interrupt_out}, 8'h00);
      wait_ready();
      rdw(ADDR_COMMAND_STATUS);
      chk8(rd[31:24], STATUS_READY);
      $display("test startup done");
      rdw(10'h224);
      chk(rd, 32'h0);
      foreach (reg_addr[i])
      begin
         wr(reg_addr[i], reg_data[i]);
         rdw(reg_addr[i]);
         chk(rd, reg_exp[i]);
      end
      $display("test regions done");
      wr(ADDR_GLOBAL_CONFIG, 32'ha5000000);
      wr(ADDR_MUX_DELAY, 32'h3c000000);
      cyc(2);
      chk8(global_config, 8'ha5);
      chk8(mux_delay, 8'h3c);
      rdw(ADDR_MUX_DELAY);
      chk8(rd[31:24], 8'h3c);
      $display("test config done");
      foreach (bad_op[i])
      begin
         spi_host_model_inst.frame(bad_op[i], ADDR_GLOBAL_CONFIG, 32'h11000000, rd);
         chk8(rd[31:24], 8'h00);
      end
      cyc(2);
      chk8(global_config, 8'ha5);
      $display("test invalid done");
      wr(ADDR_ASSIGN_FIRST + 10'h004, 32'h19c00012);
      wr(ADDR_COMMAND_STATUS, 32'h82000000);
      chk(32'(starts), 32'h1);
      chk8({3'h0, meas_channel}, 8'h02);
      chk8({3'h0, meas_pair_channel}, 8'h07);
      chk8({3'h0, meas_sensor_type}, 8'h03);
      chk8({7'h0, interrupt_out}, 8'h00);
      rdw(ADDR_COMMAND_STATUS);
      chk8(rd[31:24], 8'h82);
      rdw(ADDR_ASSIGN_FIRST + 10'h004);
      chk(rd, 32'h0);
      wr(ADDR_GLOBAL_CONFIG, 32'h5a000000);
      @(posedge clock);
      meas_result <= 32'hcafe1234;
      meas_done <= 1'b1;
      @(posedge clock);
      meas_done <= 1'b0;
      cyc(2);
      chk8({7'h0, interrupt_out}, 8'h01);
      rdw(ADDR_COMMAND_STATUS);
      chk8(rd[31:24], 8'h42);
      rdw(ADDR_RESULT_FIRST + 10'h004);
      chk(rd, 32'hcafe1234);
      chk8(global_config, 8'ha5);
      chk8({7'h0, miso_oe}, 8'h00);
      wr(ADDR_COMMAND_STATUS, 32'h85000000);
      chk(32'(starts), 32'h1);
      chk8({7'h0, interrupt_out}, 8'h01);
      rdw(ADDR_COMMAND_STATUS);
      chk8(rd[31:24], 8'h45);
      wr(ADDR_COMMAND_STATUS, 32'h03000000);
      rdw(ADDR_COMMAND_STATUS);
      chk8(rd[31:24], 8'h03);
      $display("test conversion done");
      @(posedge clock);
      sleep_exit <= 1'b1;
      @(posedge clock);
      sleep_exit <= 1'b0;
      cyc(2);
      chk8({7'h0, interrupt_out}, 8'h00);
      wait_ready();
      rdw(ADDR_ASSIGN_FIRST + 10'h004);
      chk(rd, 32'h0);
      wr(ADDR_GLOBAL_CONFIG, 32'ha5000000);
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      cyc(2);
      chk8({7'h0, interrupt_out}, 8'h00);
      wait_ready();
      chk8(global_config, 8'h00);
      $display("test restart done");
      finish_test();
   end
endmodule : testbench
